// >>> rtl/chpd_top.sv
/*
  host port decode: mode select, access space and byte lane decode,
  status and handshake pin drive for memory, i/o and ide modes.
  assumes host pins synchronous to clock; mode strap sampled at reset release.
*/
`timescale 1ns/1ns

module chpd_top #(
  parameter int ADDR_W = chpd_pkg::CHPD_ADDR_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] mode_strap,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic reg_sel_n,
  input wire logic ce1_n,
  input wire logic ce2_n,
  input wire logic cable_sel_n,
  input wire logic data_phase,
  input wire logic card_ready,
  input wire logic write_protect,
  input wire logic [chpd_pkg::CHPD_CSR_W-1:0] csr_value,
  input wire logic sigchg_ack,
  input wire logic diag_pass,
  input wire logic drive_active,
  input wire logic pin1_in,
  input wire logic pin2_in,
  output logic [1:0] mode,
  output logic [2:0] space,
  output logic [ADDR_W-1:0] reg_index,
  output logic [1:0] lane,
  output logic lane_swap,
  output logic is_master,
  output logic pin1_out,
  output logic pin1_oe,
  output logic pin2_out,
  output logic pin2_oe,
  output logic peer_diag,
  output logic peer_present
);
  chpd_pkg::chpd_mode_t mode_q;
  logic mode_set_q;
  logic [chpd_pkg::CHPD_CSR_W-1:0] csr_q;
  logic [2:0] space_q, space_d;
  logic [ADDR_W-1:0] index_q, index_d;
  logic [1:0] lane_q, lane_d;
  logic swap_q, swap_d;
  logic master_q;
  logic p1o_q, p1e_q, p2o_q, p2e_q;
  logic p1o_d, p1e_d, p2o_d, p2e_d;
  logic diag_q, present_q;
  logic changed;
  logic is_ide, is_io, sel_any, sigchg_en;
  chpd_pkg::chpd_lane_t card_lane;
  logic card_swap;

  // ------------------------------------------------------------
  // card enable lane decode, shared by memory and io modes
  // ------------------------------------------------------------
  function automatic chpd_pkg::chpd_lane_t card_lane_f(input logic c1, input logic c2,
                                                       input logic a0);
    if (!c1 && !c2)
      card_lane_f = chpd_pkg::CHPD_LN_WORD;
    else if (!c2)
      card_lane_f = chpd_pkg::CHPD_LN_ODD;
    else if (!c1)
      card_lane_f = a0 ? chpd_pkg::CHPD_LN_ODD : chpd_pkg::CHPD_LN_EVEN;
    else
      card_lane_f = chpd_pkg::CHPD_LN_NONE;
  endfunction

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  assign is_ide = mode_q == chpd_pkg::CHPD_MODE_IDE;
  assign is_io = mode_q == chpd_pkg::CHPD_MODE_IO;
  assign sel_any = mode_set_q && (!ce1_n || !ce2_n);
  assign card_lane = card_lane_f(ce1_n, ce2_n, addr[0]);
  // odd byte presented on low lane for 8-bit hosts
  assign card_swap = !ce1_n && ce2_n && addr[0];
  assign sigchg_en = csr_q[chpd_pkg::CHPD_CSR_SIGCHG_BIT];

  // ------------------------------------------------------------
  // space, index and lane decode
  // ------------------------------------------------------------
  always_comb begin
    space_d = chpd_pkg::CHPD_SP_NONE;
    index_d = '0;
    lane_d = chpd_pkg::CHPD_LN_NONE;
    swap_d = 1'b0;
    if (sel_any) begin
      case (mode_q)
        chpd_pkg::CHPD_MODE_IDE: begin
          // upper address bits ignored
          index_d = {{(ADDR_W-3){1'b0}}, addr[2:0]};
          if (!ce1_n)
            space_d = chpd_pkg::CHPD_SP_TASK;
          else
            space_d = chpd_pkg::CHPD_SP_CTRL;
          if (data_phase)
            lane_d = chpd_pkg::CHPD_LN_WORD;
          else
            lane_d = chpd_pkg::CHPD_LN_EVEN;
        end
        chpd_pkg::CHPD_MODE_MEM, chpd_pkg::CHPD_MODE_IO: begin
          index_d = addr;
          lane_d = card_lane;
          swap_d = card_swap;
          if (!reg_sel_n) begin
            if (is_io)
              space_d = chpd_pkg::CHPD_SP_IO_REG;
            else if (addr >= chpd_pkg::CHPD_CONFIG_BASE)
              space_d = chpd_pkg::CHPD_SP_CONFIG;
            else
              space_d = chpd_pkg::CHPD_SP_ATTR;
          end else begin
            space_d = chpd_pkg::CHPD_SP_MEM_REG;
          end
        end
        default: space_d = chpd_pkg::CHPD_SP_NONE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // status and handshake pin drive
  // ------------------------------------------------------------
  always_comb begin
    p1o_d = 1'b1;
    p1e_d = 1'b0;
    p2o_d = 1'b1;
    p2e_d = 1'b0;
    if (mode_set_q) begin
      case (mode_q)
        chpd_pkg::CHPD_MODE_MEM: begin
          p1e_d = 1'b1;
          p2e_d = 1'b1;
        end
        chpd_pkg::CHPD_MODE_IO: begin
          p1e_d = 1'b1;
          p1o_d = ~(changed && sigchg_en);
          p2e_d = 1'b1;
        end
        chpd_pkg::CHPD_MODE_IDE: begin
          // open-drain style: drive low only while asserting
          p1o_d = 1'b0;
          p1e_d = diag_pass;
          p2o_d = 1'b0;
          p2e_d = drive_active;
        end
        default: begin
          p1e_d = 1'b0;
        end
      endcase
    end
  end

  chpd_edge #(
    .WIDTH(2)
  ) u_edge (
    .clock(clock),
    .rst_n(rst_n),
    .level({card_ready, write_protect}),
    .arm(is_io && mode_set_q),
    .clear(sigchg_ack),
    .changed(changed)
  );

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_q <= chpd_pkg::CHPD_MODE_MEM;
      mode_set_q <= 1'b0;
      master_q <= 1'b0;
    end else if (!mode_set_q) begin
      // strap caught once after reset release
      mode_set_q <= 1'b1;
      case (mode_strap)
        2'h1: mode_q <= chpd_pkg::CHPD_MODE_IO;
        2'h2: mode_q <= chpd_pkg::CHPD_MODE_IDE;
        default: mode_q <= chpd_pkg::CHPD_MODE_MEM;
      endcase
      master_q <= (mode_strap == 2'h2) && !cable_sel_n;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      csr_q <= chpd_pkg::CHPD_CSR_RESET;
      space_q <= chpd_pkg::CHPD_SP_NONE;
      index_q <= '0;
      lane_q <= chpd_pkg::CHPD_LN_NONE;
      swap_q <= 1'b0;
      p1o_q <= 1'b1;
      p1e_q <= 1'b0;
      p2o_q <= 1'b1;
      p2e_q <= 1'b0;
      diag_q <= 1'b0;
      present_q <= 1'b0;
    end else begin
      csr_q <= csr_value;
      space_q <= space_d;
      index_q <= index_d;
      lane_q <= lane_d;
      swap_q <= swap_d;
      p1o_q <= p1o_d;
      p1e_q <= p1e_d;
      p2o_q <= p2o_d;
      p2e_q <= p2e_d;
      diag_q <= is_ide && mode_set_q && !pin1_in;
      present_q <= is_ide && mode_set_q && !pin2_in;
    end
  end

  assign mode = mode_q;
  assign space = space_q;
  assign reg_index = index_q;
  assign lane = lane_q;
  assign lane_swap = swap_q;
  assign is_master = master_q;
  assign pin1_out = p1o_q;
  assign pin1_oe = p1e_q;
  assign pin2_out = p2o_q;
  assign pin2_oe = p2e_q;
  assign peer_diag = diag_q;
  assign peer_present = present_q;
endmodule

// >>> rtl/chpd_pkg.sv
/*
  constants and types for the card host port decoder.
  assumes a single 100 MHz clock and synchronous active-low reset.
*/
package chpd_pkg;
  // ------------------------------------------------------------
  // interface modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CHPD_MODE_MEM,
    CHPD_MODE_IO,
    CHPD_MODE_IDE
  } chpd_mode_t;

  // ------------------------------------------------------------
  // access target space
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CHPD_SP_NONE,
    CHPD_SP_MEM_REG,
    CHPD_SP_IO_REG,
    CHPD_SP_ATTR,
    CHPD_SP_CONFIG,
    CHPD_SP_TASK,
    CHPD_SP_CTRL
  } chpd_space_t;

  // ------------------------------------------------------------
  // lane selection
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CHPD_LN_NONE,
    CHPD_LN_EVEN,
    CHPD_LN_ODD,
    CHPD_LN_WORD
  } chpd_lane_t;

  localparam int CHPD_ADDR_W = 11;
  localparam int CHPD_IDE_SEL_W = 3;
  // attribute space at and above this offset holds the config registers
  localparam logic [10:0] CHPD_CONFIG_BASE = 11'h200;
  // status-change enable bit position in the config-and-status word
  localparam int CHPD_CSR_SIGCHG_BIT = 4;
  localparam int CHPD_CSR_W = 8;
  localparam logic [7:0] CHPD_CSR_RESET = 8'h00;
  localparam logic [1:0] CHPD_MODE_RESET = 2'h0;
endpackage

// >>> rtl/chpd_edge.sv
/*
  change detector that raises a sticky flag when a level toggles.
  assumes inputs synchronous to clock.
*/
`timescale 1ns/1ns
module chpd_edge #(
  parameter int WIDTH = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] level,
  input wire logic arm,
  input wire logic clear,
  output logic changed
);
  logic [WIDTH-1:0] last_q;
  logic changed_q;
  logic hit;

  // ------------------------------------------------------------
  // change detection, set wins over clear
  // ------------------------------------------------------------
  assign hit = arm && (level != last_q);
  assign changed = changed_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      last_q <= '0;
      changed_q <= 1'b0;
    end else begin
      last_q <= level;
      changed_q <= hit | (changed_q & ~clear);
    end
  end
endmodule

// >>> bench/chpd_props.sv
/*
  concurrent checks on the chpd_top ports.
  assumes bind onto chpd_top, single clock domain.
*/
`timescale 1ns/1ns
module chpd_props #(
  parameter int ADDR_W = 11
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic ce1_n,
  input wire logic ce2_n,
  input wire logic card_ready,
  input wire logic write_protect,
  input wire logic [7:0] csr_value,
  input wire logic sigchg_ack,
  input wire logic diag_pass,
  input wire logic drive_active,
  input wire logic [1:0] mode,
  input wire logic [2:0] space,
  input wire logic [ADDR_W-1:0] reg_index,
  input wire logic [1:0] lane,
  input wire logic lane_swap,
  input wire logic pin1_out,
  input wire logic pin1_oe,
  input wire logic pin2_out,
  input wire logic pin2_oe
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  localparam logic [1:0] MEM = chpd_pkg::CHPD_MODE_MEM;
  localparam logic [1:0] IO = chpd_pkg::CHPD_MODE_IO;
  localparam logic [1:0] IDE = chpd_pkg::CHPD_MODE_IDE;
  logic live_q;
  always_ff @(posedge clock) live_q <= rst_n;
  wire logic card = live_q && mode != IDE;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_held(logic [1:0] m);
    (mode == m) [*3];
  endsequence
  sequence s_chg;
    (mode == IO && live_q && csr_value[4] && !sigchg_ack &&
     ($changed(card_ready) || $changed(write_protect))) ##1 (!sigchg_ack && csr_value[4]);
  endsequence
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_mem_batt_high: assert property (s_held(MEM) |-> pin1_oe && pin1_out &&
    pin2_oe && pin2_out) else $error("battery detect pins not high");
  a_io_spkr_high: assert property (s_held(IO) |-> pin2_oe && pin2_out)
    else $error("speaker pin not high");
  a_ide_pin_drive: assert property (s_held(IDE) |-> !pin1_out && !pin2_out &&
    pin1_oe == $past(diag_pass) && pin2_oe == $past(drive_active)) else $error("ide pin drive");
  a_task_route: assert property (live_q && mode == IDE && !ce1_n && ce2_n |=>
    space == 3'h5 && reg_index == ADDR_W'($past(addr[2:0]))) else $error("task file route");
  a_ctrl_route: assert property (live_q && mode == IDE && ce1_n && !ce2_n |=>
    space == 3'h6) else $error("control route");
  a_word_lane: assert property (card && !ce1_n && !ce2_n |=> lane == 2'h3)
    else $error("word lane");
  a_even_odd: assert property (card && !ce1_n && ce2_n |=> lane_swap == $past(addr[0]) &&
    lane == ($past(addr[0]) ? 2'h2 : 2'h1)) else $error("byte lane");
  a_mode_hold: assert property (live_q && $past(live_q) |-> $stable(mode))
    else $error("mode changed");
  a_stschg_low: assert property (s_chg |=> !pin1_out)
    else $error("status change not signalled");
  a_stschg_mask: assert property ((mode == IO && live_q && !csr_value[4]) [*3] |->
    pin1_out) else $error("masked status change");
endmodule
bind chpd_top chpd_props #(.ADDR_W(ADDR_W)) u_props (.clock, .rst_n, .addr, .ce1_n, .ce2_n,
  .card_ready, .write_protect, .csr_value, .sigchg_ack, .diag_pass, .drive_active, .mode,
  .space, .reg_index, .lane, .lane_swap, .pin1_out, .pin1_oe, .pin2_out, .pin2_oe);

// >>> bench/chpd_host_peer.sv
/*
  far side peer on the two shared handshake lines.
  assumes pull-ups on both lines; any driver low wins.
*/
`timescale 1ns/1ns
module chpd_host_peer (
  input wire logic pin1_out,
  input wire logic pin1_oe,
  input wire logic pin2_out,
  input wire logic pin2_oe,
  input wire logic peer_diag_low,
  input wire logic peer_busy_low,
  output logic pin1_in,
  output logic pin2_in
);
  assign pin1_in = !(peer_diag_low || (pin1_oe && !pin1_out));
  assign pin2_in = !(peer_busy_low || (pin2_oe && !pin2_out));
endmodule

// >>> bench/chpd_top_tb.sv
/*
  testbench for chpd_top: decode table, pin modes, status change.
  assumes chpd_host_peer resolves the shared lines.
*/
`timescale 1ns/1ns
`define CHK(nm, ex, ac) begin n_tests++; if ((ac) !== (ex)) begin err_total++; \
  $display("unexpected %s exp %h got %h", nm, ex, ac); end end
module chpd_top_tb;
  typedef struct packed {
    logic [1:0] md; logic c1; logic c2; logic rg; logic dp; logic [10:0] a;
    logic [2:0] sp; logic [1:0] ln; logic sw;
  } chpd_row_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] mode_strap = 2'h0;
  logic [10:0] addr = 11'h000;
  logic reg_sel_n = 1'b1, ce1_n = 1'b1, ce2_n = 1'b1, cable_sel_n = 1'b1, data_phase = 1'b0;
  logic card_ready = 1'b0, write_protect = 1'b0, sigchg_ack = 1'b0;
  logic [7:0] csr_value = 8'h00;
  logic diag_pass = 1'b0, drive_active = 1'b0, peer_diag_low = 1'b0, peer_busy_low = 1'b0;
  logic pin1_in, pin2_in, lane_swap, is_master, pin1_out, pin1_oe, pin2_out, pin2_oe;
  logic peer_diag, peer_present;
  logic [1:0] mode, lane;
  logic [2:0] space;
  logic [10:0] reg_index;
  int err_total = 0, n_tests = 0, cyc = 0;
  chpd_row_t rows [11];
  chpd_top u_chpd_top (.clock, .rst_n, .mode_strap, .addr, .reg_sel_n, .ce1_n, .ce2_n,
    .cable_sel_n, .data_phase, .card_ready, .write_protect, .csr_value, .sigchg_ack,
    .diag_pass, .drive_active, .pin1_in, .pin2_in, .mode, .space, .reg_index, .lane,
    .lane_swap, .is_master, .pin1_out, .pin1_oe, .pin2_out, .pin2_oe, .peer_diag, .peer_present);
  chpd_host_peer u_chpd_host_peer (.pin1_out, .pin1_oe, .pin2_out, .pin2_oe, .peer_diag_low,
    .peer_busy_low, .pin1_in, .pin2_in);
  always #5 clock = ~clock;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] m, input logic cs);
    rst_n = 1'b0;
    mode_strap = m;
    cable_sel_n = cs;
    {ce1_n, ce2_n} = 2'h3;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    `CHK("mode", m, mode)
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      close_out();
    end
  end
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    rows[0] = '{2'h0, 1'h0, 1'h0, 1'h1, 1'h0, 11'h004, 3'h1, 2'h3, 1'h0};
    rows[1] = '{2'h0, 1'h0, 1'h1, 1'h1, 1'h0, 11'h005, 3'h1, 2'h2, 1'h1};
    rows[2] = '{2'h0, 1'h0, 1'h1, 1'h0, 1'h0, 11'h1fe, 3'h3, 2'h1, 1'h0};
    rows[3] = '{2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 11'h200, 3'h4, 2'h2, 1'h0};
    rows[4] = '{2'h0, 1'h1, 1'h1, 1'h0, 1'h0, 11'h200, 3'h0, 2'h0, 1'h0};
    rows[5] = '{2'h1, 1'h0, 1'h1, 1'h0, 1'h0, 11'h201, 3'h2, 2'h2, 1'h1};
    rows[6] = '{2'h1, 1'h1, 1'h0, 1'h1, 1'h0, 11'h010, 3'h1, 2'h2, 1'h0};
    rows[7] = '{2'h1, 1'h0, 1'h0, 1'h0, 1'h0, 11'h7ff, 3'h2, 2'h3, 1'h0};
    rows[8] = '{2'h2, 1'h0, 1'h1, 1'h1, 1'h0, 11'h7fd, 3'h5, 2'h1, 1'h0};
    rows[9] = '{2'h2, 1'h1, 1'h0, 1'h1, 1'h0, 11'h006, 3'h6, 2'h1, 1'h0};
    rows[10] = '{2'h2, 1'h0, 1'h1, 1'h1, 1'h1, 11'h000, 3'h5, 2'h3, 1'h0};
    foreach (rows[i]) begin
      if (i == 0 || rows[i].md != mode_strap) do_reset(rows[i].md, 1'b1);
      {ce1_n, ce2_n, reg_sel_n, data_phase, addr} = {rows[i].c1, rows[i].c2, rows[i].rg,
        rows[i].dp, rows[i].a};
      @(negedge clock);
      `CHK("space", rows[i].sp, space)
      `CHK("lane", {rows[i].ln, rows[i].sw}, {lane, lane_swap})
      if (rows[i].md == 2'h2) begin
        `CHK("index", {8'h00, rows[i].a[2:0]}, reg_index)
      end else if (rows[i].sp != 3'h0) begin
        `CHK("card index", rows[i].a, reg_index)
      end
    end
    do_reset(2'h0, 1'b1);
    `CHK("bvd", 4'hf, {pin1_out, pin1_oe, pin2_out, pin2_oe})
    mode_strap = 2'h2;
    repeat (2) @(negedge clock);
    `CHK("held mode", 2'h0, mode)
    do_reset(2'h1, 1'b1);
    `CHK("spkr", 2'h3, {pin2_out, pin2_oe})
    csr_value = 8'h10;
    repeat (2) @(negedge clock);
    card_ready = 1'b1;
    repeat (3) @(negedge clock);
    `CHK("stschg", 1'b0, pin1_out)
    sigchg_ack = 1'b1;
    @(negedge clock);
    sigchg_ack = 1'b0;
    repeat (2) @(negedge clock);
    `CHK("stschg ack", 1'b1, pin1_out)
    csr_value = 8'h00;
    repeat (2) @(negedge clock);
    write_protect = 1'b1;
    repeat (4) @(negedge clock);
    `CHK("stschg mask", 1'b1, pin1_out)
    do_reset(2'h2, 1'b0);
    `CHK("master", 1'b1, is_master)
    {diag_pass, peer_busy_low} = 2'h3;
    repeat (2) @(negedge clock);
    `CHK("pdiag", 2'h2, {pin1_oe, pin1_out})
    `CHK("present", 1'b1, peer_present)
    {diag_pass, drive_active, peer_diag_low} = 3'h3;
    repeat (2) @(negedge clock);
    `CHK("peer diag", 1'b1, peer_diag)
    `CHK("dasp", 2'h2, {pin2_oe, pin2_out})
    {diag_pass, drive_active, peer_diag_low, peer_busy_low} = 4'h0;
    repeat (2) @(negedge clock);
    `CHK("peer idle", 2'h0, {peer_diag, peer_present})
    do_reset(2'h2, 1'b1);
    `CHK("slave", 1'b0, is_master)
    close_out();
  end
endmodule
